// *** logic/dpt_defs.vh ***
`ifndef DPT_DEFS_VH
`define DPT_DEFS_VH
`define DPT_LANES        4
`define DPT_BITS         8
`define DPT_TAP_W        7
`define DPT_TAP_MAX      7'h7f
`define DPT_VREF_HALF    8'h80
`define DPT_LOCK_WAIT    16'h0040
`define DPT_ALIGN_WAIT   16'h0010
`define DPT_PASS_MIN     7'h04
`endif

// *** logic/dpt_delay_mem.v ***
`timescale 1ns/10ps
// Small memory of per-bit and per-lane delay values; read data is registered.
module dpt_delay_mem
(
	input  wire       clk,
	input  wire       wr_en,
	input  wire [5:0] wr_addr,
	input  wire [6:0] wr_data,
	input  wire [5:0] rd_addr,
	output reg  [6:0] rd_data
);
	reg [6:0] mem_q [0:63];

	always @(posedge clk)
	begin
		if (wr_en)
			mem_q[wr_addr] <= wr_data;
		rd_data <= mem_q[rd_addr];
	end
endmodule // dpt_delay_mem

// *** logic/dpt_training_engine.v ***
`timescale 1ns/10ps
`include "dpt_defs.vh"
module dpt_training_engine
(
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        pll_lock,
	input  wire        fast_sim,
	input  wire        wrlvl_en,
	input  wire        wrlvl_strobe,
	input  wire [3:0]  wrlvl_prime_dq,
	input  wire        rdlvl_gate_en,
	input  wire        rdlvl_en,
	input  wire [3:0]  gate_match,
	input  wire [31:0] rd_pass,
	input  wire [5:0]  dly_rd_addr,
	output reg         init_complete,
	output reg         pll_init,
	output reg         clk_switch,
	output reg  [7:0]  vref_code,
	output reg         hs_align,
	output reg         ck_align,
	output reg  [3:0]  wrlvl_resp,
	output reg  [3:0]  rdlvl_resp,
	output reg  [6:0]  lane_tap,
	output reg  [6:0]  dly_rd_data
);
	localparam ST_PLL    = 3'h0;
	localparam ST_SWITCH = 3'h1;
	localparam ST_HSALGN = 3'h2;
	localparam ST_CKALGN = 3'h3;
	localparam ST_READY  = 3'h4;

	reg  [2:0]  st_q;
	reg  [15:0] cnt_q;
	reg  [2:0]  lock_sync_q;
	reg  [2:0]  wl_sync_q [0:3];
	reg  [3:0]  wl_done_q;
	reg  [6:0]  wl_tap_q [0:3];
	reg  [3:0]  gate_done_q;
	reg  [6:0]  gate_tap_q;
	reg  [6:0]  sweep_q;
	reg  [6:0]  left_q [0:31];
	reg  [6:0]  run_q [0:31];
	reg  [31:0] in_pass_q;
	reg         eye_done_q;
	reg         wl_saved_q;
	reg         mem_we;
	reg  [5:0]  mem_wa;
	reg  [6:0]  mem_wd;
	wire [6:0]  mem_rd;
	wire        lock_ok = lock_sync_q[1] & lock_sync_q[2];
	integer     i;
	integer     j;

	// Centre of a passing window starting at left with the given length.
	function [6:0] dpt_centre;
		input [6:0] left;
		input [6:0] len;
		begin
			dpt_centre = left + {1'b0, len[6:1]};
		end
	endfunction

	dpt_delay_mem u_mem
	(
		.clk     (clk),
		.wr_en   (mem_we),
		.wr_addr (mem_wa),
		.wr_data (mem_wd),
		.rd_addr (dly_rd_addr),
		.rd_data (mem_rd)
	);

	// Clock bring-up runs without any controller involvement.
	always @(posedge clk)
	begin
		lock_sync_q <= {lock_sync_q[1:0], pll_lock};
		if (sys_rst)
		begin
			st_q          <= ST_PLL;
			cnt_q         <= 16'h0000;
			init_complete <= 1'b0;
			pll_init      <= 1'b0;
			clk_switch    <= 1'b0;
			vref_code     <= 8'h00;
			hs_align      <= 1'b0;
			ck_align      <= 1'b0;
		end
		else
		begin
			case (st_q)
			ST_PLL:
			begin
				pll_init <= 1'b1;
				if (lock_ok)
				begin
					cnt_q <= cnt_q + 16'h0001;
					if (cnt_q == `DPT_LOCK_WAIT)
					begin
						st_q  <= ST_SWITCH;
						cnt_q <= 16'h0000;
					end
				end
				else
					cnt_q <= 16'h0000;
			end
			ST_SWITCH:
			begin
				clk_switch <= 1'b1;
				vref_code  <= `DPT_VREF_HALF;
				st_q       <= ST_HSALGN;
			end
			ST_HSALGN:
			begin
				cnt_q <= cnt_q + 16'h0001;
				if (cnt_q == `DPT_ALIGN_WAIT)
				begin
					hs_align <= 1'b1;
					cnt_q    <= 16'h0000;
					st_q     <= ST_CKALGN;
				end
			end
			ST_CKALGN:
			begin
				cnt_q <= cnt_q + 16'h0001;
				if (cnt_q == `DPT_ALIGN_WAIT)
				begin
					ck_align <= 1'b1;
					st_q     <= ST_READY;
				end
			end
			ST_READY:
				init_complete <= 1'b1;
			default:
				st_q <= ST_PLL;
			endcase
		end
	end

	// Per-lane write leveling; prime DQ bits come from the pins.
	// One process for all lanes keeps a single driver on each lane vector.
	always @(posedge clk)
	begin
		for (j = 0; j < `DPT_LANES; j = j + 1)
		begin
			wl_sync_q[j] <= {wl_sync_q[j][1:0], wrlvl_prime_dq[j]};
			if (sys_rst)
			begin
				wl_done_q[j]  <= 1'b0;
				wl_tap_q[j]   <= 7'h00;
				wrlvl_resp[j] <= 1'b0;
			end
			else if (!wrlvl_en || fast_sim || !init_complete)
				wrlvl_resp[j] <= 1'b0;
			else if (!wl_done_q[j])
			begin
				// A stable sampled 1 marks the 0-to-1 edge after stepping from 0.
				if (wl_sync_q[j][1] & wl_sync_q[j][2])
					wl_done_q[j] <= 1'b1;
				else if (wrlvl_strobe && wl_tap_q[j] != `DPT_TAP_MAX)
					wl_tap_q[j] <= wl_tap_q[j] + 7'h01;
			end
			else if (wrlvl_strobe)
				wrlvl_resp[j] <= &wl_done_q;
		end
	end

	// Eye training and the write-level save share the tap sweep counter; gate training steps gate_tap_q.
	always @(posedge clk)
	begin
		mem_we <= 1'b0;
		mem_wa <= 6'h00;
		mem_wd <= 7'h00;
		if (sys_rst)
		begin
			gate_done_q <= 4'h0;
			gate_tap_q  <= 7'h00;
			sweep_q     <= 7'h00;
			eye_done_q  <= 1'b0;
			wl_saved_q  <= 1'b0;
			in_pass_q   <= 32'h0;
			rdlvl_resp  <= 4'h0;
			lane_tap    <= 7'h00;
			for (i = 0; i < 32; i = i + 1)
			begin
				left_q[i] <= 7'h00;
				run_q[i]  <= 7'h00;
			end
		end
		else if (rdlvl_gate_en && init_complete)
		begin
			for (i = 0; i < `DPT_LANES; i = i + 1)
				if (gate_match[i])
					gate_done_q[i] <= 1'b1;
			if (!(&gate_done_q))
				gate_tap_q <= gate_tap_q + 7'h01;
			rdlvl_resp <= {4{&gate_done_q}};
		end
		else if (rdlvl_en && init_complete && !fast_sim)
		begin
			if (!eye_done_q)
			begin
				for (i = 0; i < 32; i = i + 1)
				begin
					in_pass_q[i] <= rd_pass[i];
					if (rd_pass[i] && !in_pass_q[i] && run_q[i] == 7'h00)
						left_q[i] <= sweep_q;
					// Saturate so a window spanning every tap does not wrap to zero.
					if (rd_pass[i] && run_q[i] != `DPT_TAP_MAX)
						run_q[i] <= run_q[i] + 7'h01;
				end
				sweep_q <= sweep_q + 7'h01;
				if (sweep_q == `DPT_TAP_MAX)
				begin
					eye_done_q <= 1'b1;
					sweep_q    <= 7'h00;
				end
			end
			else if (sweep_q[5] == 1'b0)
			begin
				mem_we  <= 1'b1;
				mem_wa  <= {1'b0, sweep_q[4:0]};
				mem_wd  <= (run_q[sweep_q[4:0]] < `DPT_PASS_MIN) ? 7'h00 :
					dpt_centre(left_q[sweep_q[4:0]], run_q[sweep_q[4:0]]);
				sweep_q <= sweep_q + 7'h01;
			end
			else
				rdlvl_resp <= 4'hf;
		end
		else if (wrlvl_en && !(&wl_done_q))
			rdlvl_resp <= 4'h0;
		else if (&wl_done_q && !wl_saved_q)
		begin
			// Park each lane's leveled delay in the upper memory half.
			mem_we  <= 1'b1;
			mem_wa  <= {4'h8, sweep_q[1:0]};
			mem_wd  <= wl_tap_q[sweep_q[1:0]];
			rdlvl_resp <= 4'h0;
			if (sweep_q[1:0] == 2'h3)
			begin
				wl_saved_q <= 1'b1;
				sweep_q    <= 7'h00;
			end
			else
				sweep_q <= sweep_q + 7'h01;
		end
		else
		begin
			rdlvl_resp <= 4'h0;
			if (!rdlvl_en)
			begin
				eye_done_q <= 1'b0;
				sweep_q    <= 7'h00;
			end
		end
		lane_tap <= gate_tap_q;
		dly_rd_data <= mem_rd;
	end
endmodule // dpt_training_engine

// *** testbench/dpt_ctrl_model.sv ***
`timescale 1ns/10ps
module dpt_ctrl_model
(
	input wire logic       clk,
	input wire logic       init_complete,
	input wire logic [3:0] wrlvl_resp,
	input wire logic [3:0] rdlvl_resp,
	output logic           wrlvl_en,
	output logic           wrlvl_strobe,
	output logic [3:0]     wrlvl_prime_dq,
	output logic           rdlvl_gate_en,
	output logic           rdlvl_en,
	output logic [3:0]     gate_match
);
	initial {wrlvl_en, wrlvl_strobe, wrlvl_prime_dq, rdlvl_gate_en, rdlvl_en, gate_match} = 0;
	// Runs one step (0 write level, 1 gate, 2 eye); t is the reply delay, or -1 if none.
	task automatic step(input integer s, output integer t);
		integer n;
		begin
			t = -1;
			if (init_complete !== 1'b1)
				return;
			@(posedge clk);
			wrlvl_en <= (s == 0);
			rdlvl_gate_en <= (s == 1);
			rdlvl_en <= (s == 2);
			for (n = 0; n < 1000 && t < 0; n++)
			begin
				@(posedge clk);
				if (s == 0 ? &wrlvl_resp : &rdlvl_resp)
					t = n;
				wrlvl_strobe <= (s == 0) && !wrlvl_strobe;
				wrlvl_prime_dq <= {n > 32, n > 24, n > 16, n > 8} & {4{s == 0}};
				gate_match <= {4{s == 1 && n > 20}};
			end
			// Mode register, calibration and read commands have no pins here.
			@(posedge clk);
			{wrlvl_en, wrlvl_strobe, wrlvl_prime_dq, rdlvl_gate_en, rdlvl_en, gate_match} <= 0;
		end
	endtask
endmodule // dpt_ctrl_model

// *** testbench/dpt_training_engine_bench.sv ***
`timescale 1ns/10ps
module dpt_training_engine_bench;
	logic        clk;
	logic        sys_rst;
	logic        pll_lock;
	logic        fast_sim;
	logic [31:0] rd_pass = 32'h0;
	wire         ic;
	wire  [7:0]  vref;
	wire  [3:0]  wl_resp;
	wire  [3:0]  rl_resp;
	wire         wl_en;
	wire         wl_stb;
	wire         gl_en;
	wire         rl_en;
	wire  [3:0]  wl_dq;
	wire  [3:0]  g_match;
	wire         pll_i;
	wire         hs_al;
	wire         ck_al;
	wire  [6:0]  dly;
	logic [5:0]  rd_addr = 6'h00;
	integer      num_errors;
	integer      check_count;
	integer      seed;
	integer      t;
	integer      i;
	dpt_training_engine uut (.clk(clk), .sys_rst(sys_rst), .pll_lock(pll_lock),
		.fast_sim(fast_sim), .wrlvl_en(wl_en), .wrlvl_strobe(wl_stb), .wrlvl_prime_dq(wl_dq),
		.rdlvl_gate_en(gl_en), .rdlvl_en(rl_en), .gate_match(g_match), .rd_pass(rd_pass),
		.dly_rd_addr(rd_addr), .init_complete(ic), .pll_init(pll_i), .clk_switch(),
		.vref_code(vref), .hs_align(hs_al), .ck_align(ck_al), .wrlvl_resp(wl_resp),
		.rdlvl_resp(rl_resp), .lane_tap(), .dly_rd_data(dly));
	dpt_ctrl_model m (.clk(clk), .init_complete(ic), .wrlvl_resp(wl_resp), .rdlvl_resp(rl_resp),
		.wrlvl_en(wl_en), .wrlvl_strobe(wl_stb), .wrlvl_prime_dq(wl_dq), .rdlvl_gate_en(gl_en),
		.rdlvl_en(rl_en), .gate_match(g_match));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Full-pass data during the eye sweep puts every bit's centre at 7'h3f or 7'h40.
	always @(posedge clk)
		rd_pass <= rl_en ? 32'hffffffff : $random(seed);
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp)
			begin
				num_errors = num_errors + 1;
				$display("ERROR %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task automatic bring_up(input logic fs);
		begin
			@(posedge clk);
			sys_rst <= 1'b1;
			fast_sim <= fs;
			pll_lock <= 1'b0;
			repeat (5) @(posedge clk);
			sys_rst <= 1'b0;
			repeat (100) @(posedge clk);
			check("init_low", ic, 1'b0);
			pll_lock <= 1'b1;
			for (t = 0; t < 300 && ic !== 1'b1; t++)
				@(posedge clk);
			check("init_high", ic, 1'b1);
			check("vref", vref, 8'h80);
			check("bring_up", {pll_i, hs_al, ck_al}, 3'h7);
		end
	endtask
	task automatic complete_run;
		begin
			$display("checks %0d errors %0d", check_count, num_errors);
			if (num_errors == 0 && check_count > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors = num_errors + 1;
		complete_run;
	end
	initial
	begin
		seed = 32'h8e06;
		num_errors = 0;
		check_count = 0;
		sys_rst = 1'b1;
		fast_sim = 1'b0;
		pll_lock = 1'b0;
		bring_up(1'b0);
		for (i = 0; i < 3; i++)
		begin
			m.step(i, t);
			check("step_reply", t >= 0, 1'b1);
		end
		check("eye_sweep", t >= 128, 1'b1);
		rd_addr <= 6'h00;
		repeat (3) @(posedge clk);
		check("eye_centre", dly >= 7'h3f && dly <= 7'h40, 1'b1);
		rd_addr <= 6'h20;
		repeat (3) @(posedge clk);
		check("wl_tap", dly != 7'h00, 1'b1);
		$display("test normal done");
		bring_up(1'b1);
		m.step(0, t);
		check("fast_wl", t, -1);
		m.step(2, t);
		check("fast_eye", t, -1);
		$display("test fast done");
		complete_run;
	end
endmodule // dpt_training_engine_bench

// *** testbench/dpt_training_engine_sva.sv ***
`timescale 1ns/10ps
module dpt_chk
(
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       fast_sim,
	input wire logic       wrlvl_en,
	input wire logic       rdlvl_en,
	input wire logic       rdlvl_gate_en,
	input wire logic       init_complete,
	input wire logic       clk_switch,
	input wire logic [7:0] vref_code,
	input wire logic [3:0] wrlvl_resp,
	input wire logic [3:0] rdlvl_resp
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_init_order: assert property (!clk_switch |-> !init_complete) else $error("init early");
	chk_init_hold: assert property (init_complete |=> init_complete) else $error("init fell");
	chk_vref_half: assert property (init_complete |-> vref_code == 8'h80) else $error("vref");
	chk_wl_fast: assert property (fast_sim |-> wrlvl_resp == 4'h0) else $error("wl in fast");
	chk_wl_clear: assert property (!wrlvl_en |=> wrlvl_resp == 4'h0) else $error("wl held");
	chk_rl_pair: assert property (rdlvl_en |-> rdlvl_resp inside {4'h0, 4'hf}) else $error("rl");
	chk_rl_clear: assert property (!rdlvl_en && !rdlvl_gate_en |=> rdlvl_resp == 4'h0)
		else $error("rl held");
	chk_eye_time: assert property ($rose(rdlvl_en) && init_complete && !fast_sim
		|-> ##[100:400] rdlvl_resp == 4'hf) else $error("eye late");
endmodule // dpt_chk
bind dpt_training_engine dpt_chk chk (.clk(clk), .sys_rst(sys_rst), .fast_sim(fast_sim),
	.wrlvl_en(wrlvl_en), .rdlvl_en(rdlvl_en), .rdlvl_gate_en(rdlvl_gate_en),
	.init_complete(init_complete), .clk_switch(clk_switch), .vref_code(vref_code),
	.wrlvl_resp(wrlvl_resp), .rdlvl_resp(rdlvl_resp));
